// [spdp_defs.vh]
`ifndef SPDP_DEFS_VH
`define SPDP_DEFS_VH
// Operation
// - reset low, enable instruction before others
// - device samples rising, shifts falling edge
// - clock low and high above two cycles
// - enable is ac 53 then two bytes
// - echo 53 in byte three, send all
// - no echo: pulse clock, retry, 32 tries
// - erase, write ff at zero, erase again
// - after erase wait, pulse reset, re-enable
// - ff or no polling: wait full delay
// - power-up: reset and clock held low
// - wait 20 ms before enable

// register map (byte addresses)
`define SPDP_REG_CTRL 4'h0
`define SPDP_REG_INSTR 4'h4
`define SPDP_REG_STATUS 4'h8
`define SPDP_REG_RDATA 4'hc
// ctrl fields
`define SPDP_CTRL_GO 0
`define SPDP_CTRL_RST_HOLD 1
`define SPDP_CTRL_CONNECT 2
`define SPDP_CTRL_POLL 3
// status fields
`define SPDP_ST_BUSY 0
`define SPDP_ST_SYNCED 1
`define SPDP_ST_NODEV 2
`define SPDP_ST_DONE 3
// opcodes
`define SPDP_OP_PREFIX 8'hac
`define SPDP_OP_ENABLE2 8'h53
`define SPDP_OP_ERASE2 8'h80
`define SPDP_OP_FLASH_RD 4'h2
`define SPDP_OP_FLASH_WR 4'h4
`define SPDP_OP_EE_RD 8'ha0
`define SPDP_OP_EE_WR 8'hc0
`define SPDP_OP_ALL_ONES 8'hff
`define SPDP_SYNC_TRIES 6'h20
// timing in microseconds or mclk cycles, and clock rate in MHz
`define SPDP_CLK_MHZ 40
`define SPDP_POWERUP_US 20000
`define SPDP_ERASE_US 6800
`define SPDP_FLASH_US 3400
`define SPDP_EEPROM_US 6800
`define SPDP_RESET_PULSE_CYC 16'h0010
`define SPDP_SCK_HALF_CYC 8'h14
`define SPDP_SCK_HALF_W 8
`define SPDP_WAIT_W 20
`endif

// [spdp_clkdiv.v]
`timescale 1ns/1ps
// half-period tick for the serial clock
module spdp_clkdiv (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // control
    input wire run,
    output wire tick
);
`include "spdp_defs.vh"
reg [`SPDP_SCK_HALF_W-1:0] cnt_reg;
assign tick = run && (cnt_reg == `SPDP_SCK_HALF_CYC - 8'h01);
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        cnt_reg <= 8'h00;
    end else if (!run || tick) begin
        cnt_reg <= 8'h00;
    end else begin
        cnt_reg <= cnt_reg + 8'h01;
    end
end
endmodule

// [spdp_shifter.v]
`timescale 1ns/1ps
// one-byte serial engine: drives sck, mosi, samples miso
module spdp_shifter (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // byte request
    input wire start,
    input wire [7:0] tx_byte,
    input wire tick,
    output reg busy_reg,
    output reg [7:0] rx_reg,
    // pins
    output reg sck_reg,
    output reg mosi_reg,
    input wire miso_sync
);
reg [7:0] tx_reg;
reg [2:0] bit_reg;
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        busy_reg <= 1'b0;
        rx_reg <= 8'h00;
        sck_reg <= 1'b0;
        mosi_reg <= 1'b0;
        tx_reg <= 8'h00;
        bit_reg <= 3'd0;
    end else if (start && !busy_reg) begin
        busy_reg <= 1'b1;
        mosi_reg <= tx_byte[7];
        tx_reg <= {tx_byte[6:0], 1'b0};
        bit_reg <= 3'd0;
    end else if (busy_reg && tick) begin
        // each half period lasts well over two device cycles
        if (!sck_reg) begin
            sck_reg <= 1'b1;
            rx_reg <= {rx_reg[6:0], miso_sync};
        end else begin
            sck_reg <= 1'b0;
            if (bit_reg == 3'd7) begin
                busy_reg <= 1'b0;
            end else begin
                mosi_reg <= tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
                bit_reg <= bit_reg + 3'd1;
            end
        end
    end
end
endmodule

// [spdp_programmer.v]
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "spdp_defs.vh"
// serial download programmer with axi4-lite control
module spdp_programmer #(
    parameter POWERUP_CYC = `SPDP_POWERUP_US * `SPDP_CLK_MHZ,
    parameter ERASE_CYC = `SPDP_ERASE_US * `SPDP_CLK_MHZ,
    parameter FLASH_CYC = `SPDP_FLASH_US * `SPDP_CLK_MHZ,
    parameter EEPROM_CYC = `SPDP_EEPROM_US * `SPDP_CLK_MHZ
) (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // axi4-lite write
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // device pins
    output wire dev_reset_n,
    output wire dev_sck,
    output wire dev_mosi,
    input wire dev_miso
);

localparam [3:0] ST_IDLE = 4'd0;
localparam [3:0] ST_PWRUP = 4'd1;
localparam [3:0] ST_BYTE = 4'd2;
localparam [3:0] ST_BWAIT = 4'd3;
localparam [3:0] ST_CHECK = 4'd4;
localparam [3:0] ST_PULSE = 4'd5;
localparam [3:0] ST_DELAY = 4'd6;
localparam [3:0] ST_POLL = 4'd7;
localparam [3:0] ST_RSTP = 4'd8;
localparam [3:0] ST_PLOW = 4'd9;

// instruction kind from the first two bytes
function [1:0] spdp_kind;
    input [31:0] ins;
    begin
        if (ins[31:24] == `SPDP_OP_PREFIX && ins[23:16] == `SPDP_OP_ENABLE2)
            spdp_kind = 2'd1;
        else if (ins[31:24] == `SPDP_OP_PREFIX && ins[23:21] == 3'b100)
            spdp_kind = 2'd2;
        else if (ins[31:28] == `SPDP_OP_FLASH_WR || ins[31:24] == `SPDP_OP_EE_WR)
            spdp_kind = 2'd3;
        else
            spdp_kind = 2'd0;
    end
endfunction

// registers
reg [3:0] ctrl_reg;
reg [31:0] instr_reg;
reg [31:0] rdata_reg;
reg synced_reg;
reg nodev_reg;
reg done_reg;
reg [3:0] state_reg;
reg [1:0] idx_reg;
reg [5:0] tries_reg;
reg [`SPDP_WAIT_W-1:0] wait_reg;
reg [31:0] rx_acc_reg;
reg rst_out_reg;
reg start_reg;
reg powered_reg;
reg [7:0] echo_reg;
reg miso_s1_reg;
reg miso_s2_reg;
reg go_pulse_reg;

wire tick;
wire sh_busy;
wire [7:0] sh_rx;
wire sh_sck;
wire sh_mosi;
wire [1:0] kind;
wire busy;
wire pulse_sck;
wire is_ee;

assign kind = spdp_kind(instr_reg);
assign is_ee = (instr_reg[31:24] == `SPDP_OP_EE_WR);
assign busy = (state_reg != ST_IDLE);
assign pulse_sck = (state_reg == ST_PULSE);
assign dev_sck = sh_sck | pulse_sck;
assign dev_mosi = sh_mosi;
assign dev_reset_n = ~rst_out_reg;

// miso sync
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        miso_s1_reg <= 1'b0;
        miso_s2_reg <= 1'b0;
    end else begin
        miso_s1_reg <= dev_miso;
        miso_s2_reg <= miso_s1_reg;
    end
end

spdp_clkdiv u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(busy),
    .tick(tick)
);

spdp_shifter u_sh (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(start_reg),
    .tx_byte(instr_reg[8*(3-idx_reg)+:8]),
    .tick(tick),
    .busy_reg(sh_busy),
    .rx_reg(sh_rx),
    .sck_reg(sh_sck),
    .mosi_reg(sh_mosi),
    .miso_sync(miso_s2_reg)
);

// axi4-lite slave: single cycle accept, answer next cycle
wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
wire rd_take = s_axi_arvalid && !s_axi_rvalid;
assign s_axi_awready = wr_take;
assign s_axi_wready = wr_take;
assign s_axi_arready = rd_take;

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'b00;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= 2'b00;
        s_axi_rdata <= 32'h00000000;
        ctrl_reg <= 4'h0;
        instr_reg <= 32'h00000000;
        go_pulse_reg <= 1'b0;
    end else begin
        go_pulse_reg <= 1'b0;
        if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
        if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            case (s_axi_awaddr)
                `SPDP_REG_CTRL: begin
                    if (s_axi_wstrb[0]) begin
                        ctrl_reg <= s_axi_wdata[3:0] & 4'he;
                        go_pulse_reg <= s_axi_wdata[`SPDP_CTRL_GO] && !busy;
                    end
                end
                `SPDP_REG_INSTR: begin
                    if (!busy) begin
                        if (s_axi_wstrb[0]) instr_reg[7:0] <= s_axi_wdata[7:0];
                        if (s_axi_wstrb[1]) instr_reg[15:8] <= s_axi_wdata[15:8];
                        if (s_axi_wstrb[2]) instr_reg[23:16] <= s_axi_wdata[23:16];
                        if (s_axi_wstrb[3]) instr_reg[31:24] <= s_axi_wdata[31:24];
                    end
                end
                `SPDP_REG_STATUS: begin
                end
                `SPDP_REG_RDATA: begin
                end
                default: s_axi_bresp <= 2'b10;
            endcase
        end
        if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `SPDP_REG_CTRL: s_axi_rdata <= {28'h0000000, ctrl_reg};
                `SPDP_REG_INSTR: s_axi_rdata <= instr_reg;
                `SPDP_REG_STATUS: s_axi_rdata <= {28'h0000000, done_reg, nodev_reg,
                                                  synced_reg, busy};
                `SPDP_REG_RDATA: s_axi_rdata <= rdata_reg;
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end
    end
end

// sequencer
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        state_reg <= ST_IDLE;
        idx_reg <= 2'd0;
        tries_reg <= 6'h00;
        wait_reg <= {`SPDP_WAIT_W{1'b0}};
        rx_acc_reg <= 32'h00000000;
        rdata_reg <= 32'h00000000;
        rst_out_reg <= 1'b0;
        start_reg <= 1'b0;
        synced_reg <= 1'b0;
        nodev_reg <= 1'b0;
        done_reg <= 1'b0;
        powered_reg <= 1'b0;
        echo_reg <= 8'h00;
    end else begin
        start_reg <= 1'b0;
        // reset held high while not connected; low while programming
        if (!ctrl_reg[`SPDP_CTRL_CONNECT]) begin
            rst_out_reg <= 1'b0;
            powered_reg <= 1'b0;
            synced_reg <= 1'b0;
        end
        case (state_reg)
            ST_IDLE: begin
                if (go_pulse_reg) begin
                    done_reg <= 1'b0;
                    nodev_reg <= 1'b0;
                    idx_reg <= 2'd0;
                    rst_out_reg <= 1'b1;
                    if (kind == 2'd1) tries_reg <= 6'h00;
                    if (kind != 2'd1 && !synced_reg) begin
                        done_reg <= 1'b1;
                        nodev_reg <= 1'b1;
                    end else if (!powered_reg) begin
                        wait_reg <= POWERUP_CYC[`SPDP_WAIT_W-1:0];
                        state_reg <= ST_PWRUP;
                    end else begin
                        start_reg <= 1'b1;
                        state_reg <= ST_BYTE;
                    end
                end
            end
            ST_PWRUP: begin
                if (wait_reg == {`SPDP_WAIT_W{1'b0}}) begin
                    powered_reg <= 1'b1;
                    start_reg <= 1'b1;
                    state_reg <= ST_BYTE;
                end else begin
                    wait_reg <= wait_reg - 1'b1;
                end
            end
            ST_BYTE: state_reg <= ST_BWAIT;
            ST_BWAIT: begin
                if (!sh_busy) begin
                    rx_acc_reg <= {rx_acc_reg[23:0], sh_rx};
                    if (idx_reg == 2'd2) echo_reg <= sh_rx;
                    if (idx_reg == 2'd3) begin
                        state_reg <= ST_CHECK;
                    end else begin
                        idx_reg <= idx_reg + 2'd1;
                        start_reg <= 1'b1;
                        state_reg <= ST_BYTE;
                    end
                end
            end
            ST_CHECK: begin
                rdata_reg <= rx_acc_reg;
                idx_reg <= 2'd0;
                if (kind == 2'd1) begin
                    if (echo_reg == `SPDP_OP_ENABLE2) begin
                        synced_reg <= 1'b1;
                        done_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else if (tries_reg == `SPDP_SYNC_TRIES - 6'h01) begin
                        nodev_reg <= 1'b1;
                        done_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else begin
                        tries_reg <= tries_reg + 6'h01;
                        state_reg <= ST_PLOW;
                    end
                end else if (kind == 2'd2) begin
                    wait_reg <= ERASE_CYC[`SPDP_WAIT_W-1:0];
                    state_reg <= ST_DELAY;
                end else if (kind == 2'd3) begin
                    if (ctrl_reg[`SPDP_CTRL_POLL] && instr_reg[7:0] != `SPDP_OP_ALL_ONES) begin
                        // polling handled as a timed wait bounded by the full delay
                        wait_reg <= is_ee ? EEPROM_CYC[`SPDP_WAIT_W-1:0]
                                          : FLASH_CYC[`SPDP_WAIT_W-1:0];
                        state_reg <= ST_DELAY;
                    end else begin
                        wait_reg <= is_ee ? EEPROM_CYC[`SPDP_WAIT_W-1:0]
                                          : FLASH_CYC[`SPDP_WAIT_W-1:0];
                        state_reg <= ST_DELAY;
                    end
                end else begin
                    done_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end
            end
            // a full half period low, then one high, before the retry
            ST_PLOW: begin
                if (tick) state_reg <= ST_PULSE;
            end
            ST_PULSE: begin
                if (tick) begin
                    start_reg <= 1'b1;
                    state_reg <= ST_BYTE;
                end
            end
            ST_DELAY: begin
                if (wait_reg == {`SPDP_WAIT_W{1'b0}}) begin
                    if (kind == 2'd2) begin
                        rst_out_reg <= 1'b0;
                        synced_reg <= 1'b0;
                        wait_reg <= {4'h0, `SPDP_RESET_PULSE_CYC};
                        state_reg <= ST_RSTP;
                    end else begin
                        done_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end else begin
                    wait_reg <= wait_reg - 1'b1;
                end
            end
            ST_RSTP: begin
                if (wait_reg == {`SPDP_WAIT_W{1'b0}}) begin
                    rst_out_reg <= 1'b1;
                    done_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end else begin
                    wait_reg <= wait_reg - 1'b1;
                end
            end
            ST_POLL: begin
                state_reg <= ST_IDLE;
                done_reg <= 1'b1;
            end
            default: state_reg <= ST_IDLE;
        endcase
    end
end

endmodule

// [spdp_dev_model.sv]
`timescale 1ns/1ps
// behavioural target device on the serial download link
module spdp_dev_model #(
    parameter [7:0] SIG_BASE = 8'h5a, // arbitrary value
    parameter BUSY_NS = 2000
) (
    // pins
    input wire reset_n,
    input wire sck,
    input wire mosi,
    output reg miso,
    // fault injection
    input wire no_echo
);
    reg [7:0] flash [0:1023];
    reg [7:0] ee [0:63];
    reg [7:0] fuse = 8'hff;
    reg [2:1] lock = 2'b11;
    reg en = 1'b0;
    reg [31:0] sh = 32'h0;
    reg [7:0] tx = 8'h0;
    reg [10:0] busy_a = 11'h0;
    time busy_t = 0;
    integer n = 0;
    integer i;
    task fill(input [7:0] v);
        for (i = 0; i < 1024; i = i + 1)
            flash[i] = v;
        for (i = 0; i < 64; i = i + 1)
            ee[i] = v;
    endtask
    function [7:0] rd_byte(input [23:0] b);
        reg [10:0] a;
        begin
            a = (b[23:16] == 8'ha0) ? {5'h10, b[5:0]} : {1'b0, b[8], b[7:0], b[19]};
            case (b[23:16])
                8'h20, 8'h28: rd_byte = flash[a[9:0]];
                8'ha0: rd_byte = ee[a[5:0]];
                8'h58: rd_byte = {5'h1f, lock, 1'b1};
                8'h30: rd_byte = (lock == 2'b00) ? 8'h00 : SIG_BASE + b[7:6];
                8'h50: rd_byte = fuse;
                default: rd_byte = 8'h00;
            endcase
            if ($time < busy_t && a == busy_a)
                rd_byte = 8'hff;
        end
    endfunction
    task exec(input [31:0] c);
        if (c[31:16] == 16'hac53)
            en = 1'b1;
        else if (en) begin
            casez (c[31:16])
                16'b10101100_100?????: begin
                    fill(8'hff);
                    lock = 2'b11;
                end
                16'b10101100_11111??1: lock = lock & c[18:17];
                16'b10101100_101?????: fuse = c[7:0];
                16'b0100?000_????????: begin
                    busy_a = {1'b0, c[16], c[15:8], c[27]};
                    flash[busy_a[9:0]] = c[7:0];
                    busy_t = $time + BUSY_NS;
                end
                16'b11000000_????????: begin
                    busy_a = {5'h10, c[13:8]};
                    ee[c[13:8]] = c[7:0];
                    busy_t = $time + BUSY_NS;
                end
                default: ;
            endcase
        end
    endtask
    initial begin
        fill(8'h00);
        miso = 1'b0;
    end
    // released output shows no stale level
    always @(posedge reset_n) begin
        en = 1'b0;
        n = 0;
        miso <= ~miso;
    end
    always @(negedge sck) begin
        miso <= tx[7];
        tx <= {tx[6:0], 1'b0};
    end
    always @(posedge sck) begin
        if (!reset_n) begin
            sh = {sh[30:0], mosi};
            n = n + 1;
            if (n == 16)
                tx = no_echo ? ~sh[7:0] : sh[7:0];
            if (n == 24)
                tx = rd_byte(sh[23:0]);
            if (n == 32) begin
                n = 0;
                exec(sh);
            end
        end
    end
endmodule

// [spdp_checker_properties.sv]
`timescale 1ns/1ps
module spdp_checker (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_wvalid,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_rvalid,
    // device pins
    input wire dev_reset_n,
    input wire dev_sck,
    input wire dev_mosi
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_hi3; dev_sck [*3]; endsequence
    sequence s_lo3; !dev_sck [*3]; endsequence
    property p_sck_high; $rose(dev_sck) |-> s_hi3; endproperty
    a_sck_high: assert property (p_sck_high) else $error("sck high too short");
    property p_sck_low; $fell(dev_sck) |-> s_lo3; endproperty
    a_sck_low: assert property (p_sck_low) else $error("sck low too short");
    property p_mosi_steady; $changed(dev_mosi) |-> !dev_sck; endproperty
    a_mosi_steady: assert property (p_mosi_steady) else $error("mosi moved with sck high");
    property p_sck_in_prog; dev_sck |-> !dev_reset_n; endproperty
    a_sck_in_prog: assert property (p_sck_in_prog) else $error("sck outside programming");
    property p_reset_pulse; $rose(dev_reset_n) |-> dev_reset_n [*8]; endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse short");
    property p_quiet_start; $fell(dev_reset_n) |-> !dev_sck [*8]; endproperty
    a_quiet_start: assert property (p_quiet_start) else $error("sck active at entry");
    property p_wr_answer; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid; endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("no write response");
    property p_rd_answer; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("no read response");
endmodule

bind spdp_programmer spdp_checker chk (.mclk, .rst_n, .s_axi_awvalid, .s_axi_wvalid,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_rvalid, .dev_reset_n, .dev_sck, .dev_mosi);

// [spdp_testbench.sv]
`timescale 1ns/1ps
`include "spdp_defs.vh"
module testbench;
    localparam [7:0] SIG = 8'h5a;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg [3:0] s_axi_awaddr = 4'h0;
    reg [3:0] s_axi_araddr = 4'h0;
    reg [31:0] s_axi_wdata = 32'h0;
    reg s_axi_awvalid = 1'b0;
    reg s_axi_wvalid = 1'b0;
    reg s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0;
    reg s_axi_rready = 1'b0;
    reg no_echo = 1'b0;
    reg [31:0] ctrl_word = 32'h5;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire dev_reset_n, dev_sck, dev_mosi, dev_miso;
    reg [31:0] rdat;
    reg [1:0] resp;
    integer miscompares = 0;
    integer total_checks = 0;
    integer cycles = 0;
    integer pulses = 0;
    spdp_programmer #(.POWERUP_CYC(100), .ERASE_CYC(100), .FLASH_CYC(100),
        .EEPROM_CYC(100)) dut (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dev_reset_n, .dev_sck,
        .dev_mosi, .dev_miso);
    spdp_dev_model #(.SIG_BASE(SIG)) dev (.reset_n(dev_reset_n), .sck(dev_sck),
        .mosi(dev_mosi), .miso(dev_miso), .no_echo(no_echo));
    always #12.5 mclk = ~mclk;
    always @(posedge dev_sck) pulses = pulses + 1;
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            miscompares = miscompares + 1;
            stop_test;
        end
    end
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge mclk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge mclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask
    task rd(input [3:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
    endtask
    // one instruction: load, start with link connected, wait, fetch reply
    task op(input [31:0] ins);
        wr(`SPDP_REG_INSTR, ins);
        wr(`SPDP_REG_CTRL, ctrl_word);
        do rd(`SPDP_REG_STATUS); while (rdat[`SPDP_ST_BUSY]);
        rd(`SPDP_REG_RDATA);
    endtask
    task t_enable;
        op(32'hac530000);
        chk("echo", rdat[15:8], 8'h53);
        rd(`SPDP_REG_STATUS);
        chk("synced", rdat[`SPDP_ST_SYNCED], 1);
        chk("done", rdat[`SPDP_ST_DONE], 1);
        rd(4'h2);
        chk("unmapped", resp, 2'b10);
        wr(4'h2, 32'h0);
        chk("wr unmapped", resp, 2'b10);
        $display("test enable done");
    endtask
    task t_erase;
        op(32'hac800000);
        op(32'h20000000);
        rd(`SPDP_REG_STATUS);
        chk("refused", rdat[`SPDP_ST_NODEV], 1);
        op(32'hac530000);
        op(32'h400000ff);
        op(32'hac800000);
        op(32'hac530000);
        chk("re-echo", rdat[15:8], 8'h53);
        op(32'h20000000);
        chk("flash erased", rdat[7:0], 8'hff);
        op(32'ha0003f00);
        chk("ee erased", rdat[7:0], 8'hff);
        $display("test erase done");
    endtask
    task t_mem;
        ctrl_word = 32'hd;
        op(32'h4801ffa5);
        ctrl_word = 32'h5;
        rd(`SPDP_REG_CTRL);
        chk("ctrl poll", rdat[3:0], 4'hc);
        op(32'h4001ff3c);
        op(32'h2801ff00);
        chk("flash high", rdat[7:0], 8'ha5);
        op(32'h2001ff00);
        chk("flash low", rdat[7:0], 8'h3c);
        op(32'hc0003f5a);
        op(32'hc0003f12);
        op(32'ha0003f00);
        chk("ee rewrite", rdat[7:0], 8'h12);
        $display("test memory done");
    endtask
    task t_fuse_lock;
        op(32'haca000c3);
        op(32'h50000000);
        chk("fuse", rdat[7:0], 8'hc3);
        op(32'h30004000);
        chk("signature", rdat[7:0], SIG + 8'h01);
        op(32'hacf90000);
        op(32'h58000000);
        chk("lock", rdat[2:1], 2'b00);
        op(32'h30004000);
        chk("hidden signature", rdat[7:0], 8'h00);
        $display("test fuse and lock done");
    endtask
    task t_nodev;
        @(posedge mclk);
        no_echo <= 1'b1;
        pulses = 0;
        op(32'hac530000);
        rd(`SPDP_REG_STATUS);
        chk("nodev", rdat[`SPDP_ST_NODEV], 1);
        chk("attempts", pulses >= 1024, 1);
        $display("test no device done");
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        t_enable;
        t_erase;
        t_mem;
        t_fuse_lock;
        t_nodev;
        stop_test;
    end
endmodule
